// ===== rtl/ssr_top.sv
// status reporting core: questionable/operation registers, esr, stb, srq
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] probe supply overload sets questionable bit 1
// [R2] probe overload sets questionable bit 2
// [R3] channel overload sets questionable bit 3
// [R4] questionable temperature sets bit 4
// [R5] converter clipping sets questionable bit 5
// [R6] generator overload sets questionable bit 6
// [R7] missing alignment data sets bit 8
// [R8] limit violation sets questionable bit 9
// [R9] margin without limit violation sets bit 10
// [R10] too small signal sets bit 11
// [R11] loop lock loss sets bit 13
// [R12] enabled stb bits 2,3,4,5,7 raise srq
// [R13] stb, esr, sre and ese 8 bits, others 16
// [R14] reads return plain binary weighted value
// [R15] enable parts mask upward propagation
// [R16] questionable summary stb3, esr summary stb5
// [R17] clear-status clears events, esr, queue, not masks
// [R18] preset clears enables of operation, questionable
// [R19] preset fills positive filters, clears negative
// [R20] device clear flushes buffers, aborts parsing
// [R21] reset/preset/clear flush output at next line
// [R22] every error state appends queue entry unless 8 are already queued
// [R23] enabled transitions latch events until cleared
// [R24] controller reads queue and registers after srq
module ssr_top (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic PROBE_SUPPLY_OVERLOAD_I,
  input wire logic PROBE_OVERLOAD_I,
  input wire logic CHANNEL_OVERLOAD_I,
  input wire logic TEMPERATURE_I,
  input wire logic CONVERTER_CLIP_I,
  input wire logic GENERATOR_OVERLOAD_I,
  input wire logic UNCALIBRATED_I,
  input wire logic LIMIT_VIOLATED_I,
  input wire logic MARGIN_VIOLATED_I,
  input wire logic LOW_SIGNAL_LEVEL_I,
  input wire logic LOOP_LOCK_LOST_I,
  input wire logic [15:0] OPER_COND_I,
  input wire logic [7:0] ESR_EVENT_I,
  input wire logic OUT_AVAIL_I,
  input wire logic ERR_PUSH_I,
  input wire logic [15:0] ERR_CODE_I,
  input wire logic CLS_I,
  input wire logic STAT_PRESET_I,
  input wire logic RST_CMD_I,
  input wire logic DCL_I,
  input wire logic LINE_START_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [3:0] REG_SEL_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  output logic SRQ_O,
  output logic OUT_CLEAR_O,
  output logic INPUT_CLEAR_O
);

  ////////////////////////////////////////////////////////////////////////////
  // condition parts

  logic [15:0] ques_cond_r;
  logic [15:0] oper_cond_r;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ques_cond_r <= ssr_pkg::NTR_PRESET;
      oper_cond_r <= ssr_pkg::NTR_PRESET;
    end else begin
      ques_cond_r <= ssr_pkg::NTR_PRESET;
      ques_cond_r[ssr_pkg::QB_PROBE_SUPPLY] <= PROBE_SUPPLY_OVERLOAD_I; // see [R1]
      ques_cond_r[ssr_pkg::QB_PROBE_OVL] <= PROBE_OVERLOAD_I; // see [R2]
      ques_cond_r[ssr_pkg::QB_CHAN_OVL] <= CHANNEL_OVERLOAD_I; // see [R3]
      ques_cond_r[ssr_pkg::QB_TEMP] <= TEMPERATURE_I; // see [R4]
      ques_cond_r[ssr_pkg::QB_CLIP] <= CONVERTER_CLIP_I; // see [R5]
      ques_cond_r[ssr_pkg::QB_GEN_OVL] <= GENERATOR_OVERLOAD_I; // see [R6]
      ques_cond_r[ssr_pkg::QB_UNCAL] <= UNCALIBRATED_I; // see [R7]
      ques_cond_r[ssr_pkg::QB_LIMIT] <= LIMIT_VIOLATED_I; // see [R8]
      // margin is reported only while the limit itself is not violated
      ques_cond_r[ssr_pkg::QB_MARGIN] <=
        MARGIN_VIOLATED_I & ~LIMIT_VIOLATED_I; // see [R9]
      ques_cond_r[ssr_pkg::QB_LOW_LEVEL] <= LOW_SIGNAL_LEVEL_I; // see [R10]
      ques_cond_r[ssr_pkg::QB_LOCK] <= LOOP_LOCK_LOST_I; // see [R11]
      oper_cond_r <= OPER_COND_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and the two 16-bit registers

  logic wr_sel_qena, wr_sel_qptr, wr_sel_qntr;
  logic wr_sel_oena, wr_sel_optr, wr_sel_ontr;
  logic rd_qevt, rd_oevt, rd_esr, rd_errq;
  logic [15:0] ques_evt, ques_ena, ques_ptr, ques_ntr;
  logic [15:0] oper_evt, oper_ena, oper_ptr, oper_ntr;
  logic ques_sum, oper_sum;

  assign wr_sel_qena = REG_WR_I && (REG_SEL_I == ssr_pkg::SEL_QENA);
  assign wr_sel_qptr = REG_WR_I && (REG_SEL_I == ssr_pkg::SEL_QPTR);
  assign wr_sel_qntr = REG_WR_I && (REG_SEL_I == ssr_pkg::SEL_QNTR);
  assign wr_sel_oena = REG_WR_I && (REG_SEL_I == ssr_pkg::SEL_OENA);
  assign wr_sel_optr = REG_WR_I && (REG_SEL_I == ssr_pkg::SEL_OPTR);
  assign wr_sel_ontr = REG_WR_I && (REG_SEL_I == ssr_pkg::SEL_ONTR);
  assign rd_qevt = REG_RD_I && (REG_SEL_I == ssr_pkg::SEL_QEVT);
  assign rd_oevt = REG_RD_I && (REG_SEL_I == ssr_pkg::SEL_OEVT);
  assign rd_esr = REG_RD_I && (REG_SEL_I == ssr_pkg::SEL_ESR);
  assign rd_errq = REG_RD_I && (REG_SEL_I == ssr_pkg::SEL_ERRQ);

  ssr_status_reg ques_u (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .cond_i(ques_cond_r),
    .wdata_i(REG_WDATA_I),
    .ena_wr_i(wr_sel_qena),
    .ptr_wr_i(wr_sel_qptr),
    .ntr_wr_i(wr_sel_qntr),
    .evt_rd_i(rd_qevt),
    .clear_i(CLS_I),
    .preset_i(STAT_PRESET_I),
    .event_o(ques_evt),
    .ena_o(ques_ena),
    .ptr_o(ques_ptr),
    .ntr_o(ques_ntr),
    .summary_o(ques_sum)
  );

  ssr_status_reg oper_u (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .cond_i(oper_cond_r),
    .wdata_i(REG_WDATA_I),
    .ena_wr_i(wr_sel_oena),
    .ptr_wr_i(wr_sel_optr),
    .ntr_wr_i(wr_sel_ontr),
    .evt_rd_i(rd_oevt),
    .clear_i(CLS_I),
    .preset_i(STAT_PRESET_I),
    .event_o(oper_evt),
    .ena_o(oper_ena),
    .ptr_o(oper_ptr),
    .ntr_o(oper_ntr),
    .summary_o(oper_sum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event status register and the two 8-bit masks

  logic [7:0] esr_r;
  logic [7:0] ese_r;
  logic [7:0] sre_r;

  // a new event beats read-clear and clear-status in the same cycle
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      esr_r <= ssr_pkg::ESR_RESET;
    end else if (rd_esr || CLS_I) begin
      esr_r <= ESR_EVENT_I; // see [R17]
    end else begin
      esr_r <= esr_r | ESR_EVENT_I;
    end
  end

  // masks only change by write; no clear or preset touches them
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ese_r <= ssr_pkg::MASK8_RESET;
      sre_r <= ssr_pkg::MASK8_RESET;
    end else if (REG_WR_I) begin
      if (REG_SEL_I == ssr_pkg::SEL_ESE) begin
        ese_r <= REG_WDATA_I[7:0]; // see [R17]
      end
      if (REG_SEL_I == ssr_pkg::SEL_SRE) begin
        sre_r <= REG_WDATA_I[7:0]; // see [R17]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error queue

  logic [15:0] errq_mem [ssr_pkg::ERRQ_DEPTH];
  logic [2:0] errq_wp_r;
  logic [2:0] errq_rp_r;
  logic [3:0] errq_cnt_r;
  logic errq_full, errq_empty, errq_push, errq_pop;

  assign errq_full = errq_cnt_r == 4'(ssr_pkg::ERRQ_DEPTH);
  assign errq_empty = errq_cnt_r == 4'h0;
  // a full queue drops further entries; the oldest ones are the causes
  assign errq_push = ERR_PUSH_I && (!errq_full || CLS_I);
  assign errq_pop = rd_errq && !errq_empty && !CLS_I;

  always_ff @(posedge CLOCK_I) begin
    if (errq_push) begin
      errq_mem[CLS_I ? errq_rp_r : errq_wp_r] <= ERR_CODE_I; // see [R22]
    end
  end

  // a push in the clearing cycle survives as the only entry
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      errq_wp_r <= 3'h0;
      errq_rp_r <= 3'h0;
      errq_cnt_r <= 4'h0;
    end else if (CLS_I) begin
      errq_wp_r <= errq_push ? errq_rp_r + 3'h1 : errq_rp_r; // see [R17]
      errq_cnt_r <= errq_push ? 4'h1 : 4'h0; // see [R17]
    end else begin
      if (errq_push) begin
        errq_wp_r <= errq_wp_r + 3'h1; // see [R22]
      end
      if (errq_pop) begin
        errq_rp_r <= errq_rp_r + 3'h1;
      end
      errq_cnt_r <= errq_cnt_r + {3'h0, errq_push} - {3'h0, errq_pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status byte and service request

  logic [7:0] stb;
  logic srq_r;

  always_comb begin
    stb = 8'h00;
    stb[ssr_pkg::SB_ERRQ] = !errq_empty;
    stb[ssr_pkg::SB_QUES] = ques_sum; // see [R16]
    stb[ssr_pkg::SB_MAV] = OUT_AVAIL_I;
    stb[ssr_pkg::SB_ESB] = |(esr_r & ese_r); // see [R16] [R15]
    stb[ssr_pkg::SB_OPER] = oper_sum;
    stb[ssr_pkg::SB_MSS] = |(stb & sre_r & ssr_pkg::SRQ_BITS);
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      srq_r <= 1'b0;
    end else begin
      srq_r <= |(stb & sre_r & ssr_pkg::SRQ_BITS); // see [R12]
    end
  end

  assign SRQ_O = srq_r;

  ////////////////////////////////////////////////////////////////////////////
  // register read port: values are plain binary, weight 2**bit

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 16'h0000;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        case (REG_SEL_I)
          ssr_pkg::SEL_QCOND: REG_RDATA_O <= ques_cond_r; // see [R14]
          ssr_pkg::SEL_QEVT: REG_RDATA_O <= ques_evt;
          ssr_pkg::SEL_QENA: REG_RDATA_O <= ques_ena;
          ssr_pkg::SEL_QPTR: REG_RDATA_O <= ques_ptr;
          ssr_pkg::SEL_QNTR: REG_RDATA_O <= ques_ntr;
          ssr_pkg::SEL_OCOND: REG_RDATA_O <= oper_cond_r;
          ssr_pkg::SEL_OEVT: REG_RDATA_O <= oper_evt;
          ssr_pkg::SEL_OENA: REG_RDATA_O <= oper_ena;
          ssr_pkg::SEL_OPTR: REG_RDATA_O <= oper_ptr;
          ssr_pkg::SEL_ONTR: REG_RDATA_O <= oper_ntr;
          ssr_pkg::SEL_STB: REG_RDATA_O <= {8'h00, stb}; // see [R13]
          ssr_pkg::SEL_ESR: REG_RDATA_O <= {8'h00, esr_r}; // see [R13]
          ssr_pkg::SEL_SRE: REG_RDATA_O <= {8'h00, sre_r};
          ssr_pkg::SEL_ESE: REG_RDATA_O <= {8'h00, ese_r};
          ssr_pkg::SEL_ERRQ: begin
            REG_RDATA_O <= errq_empty ? ssr_pkg::ERR_NONE :
                           errq_mem[errq_rp_r];
          end
          default: REG_RDATA_O <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer and input flush control

  ssr_pkg::ssr_obuf_t ob_state_r;
  logic ob_arm;

  assign ob_arm = CLS_I || STAT_PRESET_I || RST_CMD_I;

  // deferred flush waits for the first command after a terminator
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ob_state_r <= ssr_pkg::OB_IDLE;
    end else begin
      case (ob_state_r)
        ssr_pkg::OB_IDLE: begin
          if (ob_arm) begin
            ob_state_r <= ssr_pkg::OB_ARMED; // see [R21]
          end
        end
        ssr_pkg::OB_ARMED: begin
          // an arm in the flushing cycle stays pending for the next line
          if (LINE_START_I) begin
            ob_state_r <= ob_arm ? ssr_pkg::OB_ARMED :
                          ssr_pkg::OB_FLUSH; // see [R21]
          end
        end
        ssr_pkg::OB_FLUSH: begin
          ob_state_r <= ob_arm ? ssr_pkg::OB_ARMED : ssr_pkg::OB_IDLE;
        end
        default: ob_state_r <= ssr_pkg::OB_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUT_CLEAR_O <= 1'b0;
      INPUT_CLEAR_O <= 1'b0;
    end else begin
      OUT_CLEAR_O <= DCL_I ||
        (ob_state_r == ssr_pkg::OB_ARMED && LINE_START_I); // see [R20] [R21]
      INPUT_CLEAR_O <= DCL_I; // see [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  chk_supply_bit: assert property ( // see [R1]
    PROBE_SUPPLY_OVERLOAD_I |=> ques_cond_r[1])
    else $error("probe supply overload not in bit 1");
  chk_probe_bit: assert property ( // see [R2]
    PROBE_OVERLOAD_I |=> ques_cond_r[2])
    else $error("probe overload not in bit 2");
  chk_channel_bit: assert property ( // see [R3]
    CHANNEL_OVERLOAD_I |=> ques_cond_r[3])
    else $error("channel overload not in bit 3");
  chk_temp_bit: assert property ( // see [R4]
    TEMPERATURE_I |=> ques_cond_r[4])
    else $error("temperature not in bit 4");
  chk_clip_bit: assert property ( // see [R5]
    CONVERTER_CLIP_I |=> ques_cond_r[5])
    else $error("clip not in bit 5");
  chk_gen_bit: assert property ( // see [R6]
    GENERATOR_OVERLOAD_I |=> ques_cond_r[6])
    else $error("generator overload not in bit 6");
  chk_uncal_bit: assert property ( // see [R7]
    UNCALIBRATED_I |=> ques_cond_r[8])
    else $error("uncalibrated not in bit 8");
  chk_limit_bit: assert property ( // see [R8]
    LIMIT_VIOLATED_I |=> ques_cond_r[9] && !ques_cond_r[10])
    else $error("limit not in bit 9 or margin shown");
  chk_margin_bit: assert property ( // see [R9]
    MARGIN_VIOLATED_I && !LIMIT_VIOLATED_I |=> ques_cond_r[10])
    else $error("margin not in bit 10");
  chk_level_lock: assert property ( // see [R10] [R11]
    LOW_SIGNAL_LEVEL_I && LOOP_LOCK_LOST_I |=> ques_cond_r[11] && ques_cond_r[13])
    else $error("low level or lock loss not reported");
  chk_srq_follow: assert property ( // see [R12]
    ##1 SRQ_O == $past(|(stb & sre_r & ssr_pkg::SRQ_BITS)))
    else $error("srq does not follow enabled status byte");
  chk_read_value: assert property ( // see [R14]
    REG_RD_I && REG_SEL_I == ssr_pkg::SEL_QCOND
    |=> REG_RVALID_O && REG_RDATA_O == $past(ques_cond_r))
    else $error("condition read value wrong");
  chk_cls_clears: assert property ( // see [R17]
    CLS_I && ESR_EVENT_I == 8'h00 && !ERR_PUSH_I && !REG_WR_I
    |=> esr_r == 8'h00 && errq_empty && $stable(sre_r) && $stable(ese_r))
    else $error("clear status incomplete");
  chk_preset_vals: assert property ( // see [R18] [R19]
    STAT_PRESET_I && !REG_WR_I |=> ques_ena == ssr_pkg::ENA_PRESET &&
    oper_ena == ssr_pkg::ENA_PRESET && ques_ptr == ssr_pkg::PTR_PRESET &&
    ques_ntr == ssr_pkg::NTR_PRESET)
    else $error("preset values wrong");
  chk_dcl_flush: assert property ( // see [R20]
    DCL_I |=> OUT_CLEAR_O && INPUT_CLEAR_O)
    else $error("device clear did not flush");
  chk_line_flush: assert property ( // see [R21]
    CLS_I && !DCL_I ##1 (!LINE_START_I && !DCL_I)[*2] ##1 LINE_START_I
    |=> OUT_CLEAR_O)
    else $error("deferred output flush missing");
  chk_queue_push: assert property ( // see [R22]
    ERR_PUSH_I && !errq_full && !rd_errq && !CLS_I
    |=> errq_cnt_r == $past(errq_cnt_r) + 4'h1)
    else $error("error not queued");
  chk_event_latch: assert property ( // see [R23]
    $rose(ques_cond_r[9]) && ques_ptr[9] |=> ques_evt[9])
    else $error("enabled rising transition not latched");

  cov_srq: cover property ($rose(SRQ_O));
  cov_deferred_flush: cover property (
    ob_state_r == ssr_pkg::OB_ARMED ##1 OUT_CLEAR_O);
  cov_queue_full: cover property (errq_full);
  cov_margin_only: cover property ($rose(ques_evt[10]));

endmodule

`default_nettype wire

// ===== rtl/ssr_pkg.sv
// constants and types shared by the status reporting block
package ssr_pkg;

  localparam int STB_W = 8;
  localparam int REG_W = 16;
  localparam int ERR_W = 16;
  localparam int ERRQ_DEPTH = 8;
  localparam int ERRQ_AW = 3;
  localparam int SEL_W = 4;

  // questionable condition bit positions
  localparam int QB_PROBE_SUPPLY = 1;
  localparam int QB_PROBE_OVL = 2;
  localparam int QB_CHAN_OVL = 3;
  localparam int QB_TEMP = 4;
  localparam int QB_CLIP = 5;
  localparam int QB_GEN_OVL = 6;
  localparam int QB_UNCAL = 8;
  localparam int QB_LIMIT = 9;
  localparam int QB_MARGIN = 10;
  localparam int QB_LOW_LEVEL = 11;
  localparam int QB_LOCK = 13;

  // status byte bit positions
  localparam int SB_ERRQ = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_MSS = 6;
  localparam int SB_OPER = 7;
  localparam logic [7:0] SRQ_BITS = 8'hBC;

  // reset and preset values
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] MASK8_RESET = 8'h00;
  localparam logic [15:0] ENA_PRESET = 16'h0000;
  localparam logic [15:0] PTR_PRESET = 16'hFFFF;
  localparam logic [15:0] NTR_PRESET = 16'h0000;
  localparam logic [15:0] ERR_NONE = 16'h0000;

  // register selects on the command port
  localparam logic [3:0] SEL_QCOND = 4'h0;
  localparam logic [3:0] SEL_QEVT = 4'h1;
  localparam logic [3:0] SEL_QENA = 4'h2;
  localparam logic [3:0] SEL_QPTR = 4'h3;
  localparam logic [3:0] SEL_QNTR = 4'h4;
  localparam logic [3:0] SEL_OCOND = 4'h5;
  localparam logic [3:0] SEL_OEVT = 4'h6;
  localparam logic [3:0] SEL_OENA = 4'h7;
  localparam logic [3:0] SEL_OPTR = 4'h8;
  localparam logic [3:0] SEL_ONTR = 4'h9;
  localparam logic [3:0] SEL_STB = 4'hA;
  localparam logic [3:0] SEL_ESR = 4'hB;
  localparam logic [3:0] SEL_SRE = 4'hC;
  localparam logic [3:0] SEL_ESE = 4'hD;
  localparam logic [3:0] SEL_ERRQ = 4'hE;

  typedef enum logic [1:0] {
    OB_IDLE = 2'b00,
    OB_ARMED = 2'b01,
    OB_FLUSH = 2'b11
  } ssr_obuf_t;

endpackage

// ===== rtl/ssr_status_reg.sv
// one 16-bit status register: transition filters, event latch, enable
`timescale 1ns/1ps
`default_nettype none

module ssr_status_reg (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] cond_i,
  input wire logic [15:0] wdata_i,
  input wire logic ena_wr_i,
  input wire logic ptr_wr_i,
  input wire logic ntr_wr_i,
  input wire logic evt_rd_i,
  input wire logic clear_i,
  input wire logic preset_i,
  output logic [15:0] event_o,
  output logic [15:0] ena_o,
  output logic [15:0] ptr_o,
  output logic [15:0] ntr_o,
  output logic summary_o
);

  logic [15:0] prev_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_r <= ssr_pkg::NTR_PRESET;
    end else begin
      prev_r <= cond_i;
    end
  end

  // a write in the same cycle as a preset wins: it is the later command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ena_o <= ssr_pkg::ENA_PRESET;
      ptr_o <= ssr_pkg::PTR_PRESET;
      ntr_o <= ssr_pkg::NTR_PRESET;
    end else begin
      if (ena_wr_i) begin
        ena_o <= wdata_i;
      end else if (preset_i) begin
        ena_o <= ssr_pkg::ENA_PRESET; // see [R18]
      end
      if (ptr_wr_i) begin
        ptr_o <= wdata_i;
      end else if (preset_i) begin
        ptr_o <= ssr_pkg::PTR_PRESET; // see [R19]
      end
      if (ntr_wr_i) begin
        ntr_o <= wdata_i;
      end else if (preset_i) begin
        ntr_o <= ssr_pkg::NTR_PRESET; // see [R19]
      end
    end
  end

  // per-bit event latch; a new transition wins over a read or clear
  logic [15:0] hit;

  for (genvar b = 0; b < ssr_pkg::REG_W; b++) begin : g_evt
    assign hit[b] = (cond_i[b] & ~prev_r[b] & ptr_o[b]) |
                    (~cond_i[b] & prev_r[b] & ntr_o[b]); // see [R23]
  end

  // one process owns the whole event word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_o <= 16'h0000;
    end else if (evt_rd_i || clear_i) begin
      event_o <= hit; // see [R17] [R23]
    end else begin
      event_o <= event_o | hit; // see [R23]
    end
  end

  assign summary_o = |(event_o & ena_o); // see [R15]

endmodule

`default_nettype wire

// ===== sim/ssr_ctrl_model.sv
// remote controller model: register accesses and command pulses
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module ssr_ctrl_model (
  input wire logic clk_i,
  output logic rd_o,
  output logic wr_o,
  output logic [3:0] sel_o,
  output logic [15:0] wdata_o,
  output logic [4:0] cmd_o
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    sel_o = 4'h0;
    wdata_o = 16'h0000;
    cmd_o = 5'h00;
  end

  // select and data are scrambled once released, so a design that
  // samples them late sees garbage rather than a lucky stale value
  task automatic access(input logic w, input logic [3:0] s,
      input logic [15:0] d);
    @(posedge clk_i);
    rd_o <= ~w;
    wr_o <= w;
    sel_o <= s;
    wdata_o <= d;
    @(posedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    sel_o <= ~s;
    wdata_o <= ~d;
  endtask

  // bit 0 clear, 1 preset, 2 reset, 3 device clear, 4 line start
  task automatic pulse(input logic [4:0] c);
    @(posedge clk_i);
    cmd_o <= c;
    @(posedge clk_i);
    cmd_o <= 5'h00;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_status_reporting_srq.sv
// self-checking bench for the status reporting core
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module tb_status_reporting_srq;
  logic clk = 1'b0;
  logic rst_n;
  logic [15:0] cv, oc, ec, rdata, wd, v;
  logic [7:0] ev;
  logic oa, ep, rd, wr, srq, oclr, iclr, rv;
  logic [3:0] sel;
  logic [4:0] cmd;
  logic [15:0] expq[$];
  logic [15:0] codes[9];
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int i;

  always #2.5 clk = ~clk;

  ssr_ctrl_model i_ctrl (.clk_i(clk), .rd_o(rd), .wr_o(wr), .sel_o(sel),
    .wdata_o(wd), .cmd_o(cmd));

  ssr_top i_dut (.CLOCK_I(clk), .RST_N_I(rst_n),
    .PROBE_SUPPLY_OVERLOAD_I(cv[1]), .PROBE_OVERLOAD_I(cv[2]),
    .CHANNEL_OVERLOAD_I(cv[3]), .TEMPERATURE_I(cv[4]),
    .CONVERTER_CLIP_I(cv[5]), .GENERATOR_OVERLOAD_I(cv[6]),
    .UNCALIBRATED_I(cv[8]), .LIMIT_VIOLATED_I(cv[9]),
    .MARGIN_VIOLATED_I(cv[10]), .LOW_SIGNAL_LEVEL_I(cv[11]),
    .LOOP_LOCK_LOST_I(cv[13]), .OPER_COND_I(oc), .ESR_EVENT_I(ev),
    .OUT_AVAIL_I(oa), .ERR_PUSH_I(ep), .ERR_CODE_I(ec), .CLS_I(cmd[0]),
    .STAT_PRESET_I(cmd[1]), .RST_CMD_I(cmd[2]), .DCL_I(cmd[3]),
    .LINE_START_I(cmd[4]), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_SEL_I(sel), .REG_WDATA_I(wd), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rv), .SRQ_O(srq), .OUT_CLEAR_O(oclr),
    .INPUT_CLEAR_O(iclr));

  task automatic chk(input string n, input logic [15:0] s,
      input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // read data is judged on the falling edge, where it has settled
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (expq.size() == 0) begin
        chk("unexpected read", rdata, 16'hDEAD);
      end else begin
        chk("read data", rdata, expq.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic rdx(input logic [3:0] s, input logic [15:0] e);
    expq.push_back(e);
    i_ctrl.access(1'b0, s, 16'h0000);
  endtask

  task automatic wrx(input logic [3:0] s, input logic [15:0] d);
    i_ctrl.access(1'b1, s, d);
  endtask

  task automatic setc(input logic [15:0] q, input logic [15:0] o);
    @(posedge clk);
    cv <= q;
    oc <= o;
    repeat (2) @(posedge clk);
  endtask

  task automatic srq_is(input logic e);
    repeat (4) @(posedge clk);
    #1;
    chk("srq", {15'h0000, srq}, {15'h0000, e});
  endtask

  task automatic pl(input logic [4:0] c, input logic eo, input logic ei);
    i_ctrl.pulse(c);
    #1;
    chk("clears", {14'h0000, oclr, iclr}, {14'h0000, eo, ei});
  endtask

  task automatic push(input logic [15:0] c);
    @(posedge clk);
    ep <= 1'b1;
    ec <= c;
    @(posedge clk);
    ep <= 1'b0;
    ec <= ~c;
  endtask

  initial begin
    void'($urandom(32'hF6DD));
    rst_n = 1'b0;
    cv = 16'h0000;
    oc = 16'h0000;
    ev = 8'h00;
    oa = 1'b0;
    ep = 1'b0;
    ec = 16'h0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdx(ssr_pkg::SEL_QPTR, 16'hFFFF);
    rdx(ssr_pkg::SEL_QNTR, 16'h0000);
    rdx(ssr_pkg::SEL_SRE, 16'h0000);
    rdx(ssr_pkg::SEL_ESR, 16'h0080);
    rdx(ssr_pkg::SEL_ESR, 16'h0000);
    rdx(4'hF, 16'h0000);
    pl(5'h10, 1'b0, 1'b0);
    // fixed corner cases first: margin with limit, margin alone, all
    for (i = 0; i < 14; i++) begin
      v = (i == 0) ? 16'h0600 : (i == 1) ? 16'h0400 : (i == 2) ?
        16'hFFFF : 16'($urandom());
      setc(v, 16'($urandom()));
      rdx(ssr_pkg::SEL_QCOND, (v & 16'h2F7E) & ~{5'h00, v[9], 10'h000});
      rdx(ssr_pkg::SEL_OCOND, oc);
    end
    setc(16'h0000, 16'h0000);
    pl(5'h01, 1'b0, 1'b0);
    rdx(ssr_pkg::SEL_QEVT, 16'h0000);
    rdx(ssr_pkg::SEL_OEVT, 16'h0000);
    wrx(ssr_pkg::SEL_QENA, 16'h0200);
    wrx(ssr_pkg::SEL_SRE, 16'h0008);
    setc(16'h0200, 16'h0000);
    srq_is(1'b1);
    rdx(ssr_pkg::SEL_STB, 16'h0048);
    rdx(ssr_pkg::SEL_QEVT, 16'h0200);
    rdx(ssr_pkg::SEL_QEVT, 16'h0000);
    srq_is(1'b0);
    wrx(ssr_pkg::SEL_QPTR, 16'h0000);
    wrx(ssr_pkg::SEL_QNTR, 16'h0010);
    setc(16'h0010, 16'h0000);
    rdx(ssr_pkg::SEL_QEVT, 16'h0000);
    setc(16'h0000, 16'h0000);
    rdx(ssr_pkg::SEL_QEVT, 16'h0010);
    wrx(ssr_pkg::SEL_ESE, 16'h0020);
    wrx(ssr_pkg::SEL_SRE, 16'h0020);
    @(posedge clk);
    ev <= 8'h20;
    @(posedge clk);
    ev <= 8'h00;
    srq_is(1'b1);
    rdx(ssr_pkg::SEL_STB, 16'h0060);
    rdx(ssr_pkg::SEL_ESR, 16'h0020);
    srq_is(1'b0);
    wrx(ssr_pkg::SEL_SRE, 16'h0004);
    for (i = 0; i < 9; i++) begin
      codes[i] = 16'($urandom());
      push(codes[i]);
    end
    srq_is(1'b1);
    rdx(ssr_pkg::SEL_STB, 16'h0044);
    for (i = 0; i < 8; i++) begin
      rdx(ssr_pkg::SEL_ERRQ, codes[i]);
    end
    rdx(ssr_pkg::SEL_ERRQ, 16'h0000);
    wrx(ssr_pkg::SEL_SRE, 16'h0010);
    @(posedge clk);
    oa <= 1'b1;
    srq_is(1'b1);
    rdx(ssr_pkg::SEL_STB, 16'h0050);
    @(posedge clk);
    oa <= 1'b0;
    push(16'h1234);
    wrx(ssr_pkg::SEL_OENA, 16'hFFFF);
    pl(5'h01, 1'b0, 1'b0);
    rdx(ssr_pkg::SEL_ERRQ, 16'h0000);
    rdx(ssr_pkg::SEL_SRE, 16'h0010);
    rdx(ssr_pkg::SEL_ESE, 16'h0020);
    pl(5'h10, 1'b1, 1'b0);
    pl(5'h10, 1'b0, 1'b0);
    pl(5'h02, 1'b0, 1'b0);
    rdx(ssr_pkg::SEL_QENA, 16'h0000);
    rdx(ssr_pkg::SEL_OENA, 16'h0000);
    rdx(ssr_pkg::SEL_QPTR, 16'hFFFF);
    rdx(ssr_pkg::SEL_QNTR, 16'h0000);
    rdx(ssr_pkg::SEL_SRE, 16'h0010);
    pl(5'h10, 1'b1, 1'b0);
    pl(5'h04, 1'b0, 1'b0);
    pl(5'h10, 1'b1, 1'b0);
    pl(5'h08, 1'b1, 1'b1);
    rdx(ssr_pkg::SEL_SRE, 16'h0010);
    repeat (4) @(posedge clk);
    chk("pending reads", 16'(expq.size()), 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
